// ### pkg/fifo_flag_defs.svh
// constants for the almost-flag and mailbox bus-matching block
`ifndef FIFO_FLAG_DEFS_SVH
`define FIFO_FLAG_DEFS_SVH

`define DATA_W 36
`define PTR_W 11
`define PTR_ONE 11'h001
`define PTR_ZERO 11'h000

`define DEPTH_SMALL 256
`define DEPTH_LARGE 1024

`define REF_CLK_MHZ 50
`define FLAG_SYNC_SKEW_MIN_NS 60
`define FLAG_SYNC_SKEW_CYCLES ((`FLAG_SYNC_SKEW_MIN_NS * `REF_CLK_MHZ + 999) / 1000)
`define SYNC_STAGES (`FLAG_SYNC_SKEW_CYCLES - 1)

`define SYNC_CHAINS 4
`define CH_A2B_RD 0
`define CH_B2A_WR 1
`define CH_B2A_RD 2
`define CH_A2B_WR 3

`define SIZE_LONG 2'h0
`define SIZE_WORD 2'h1
`define SIZE_BYTE 2'h2

`define LAST_PIECE_LONG 2'h0
`define LAST_PIECE_WORD 2'h1
`define LAST_PIECE_BYTE 2'h3
`define PIECE_ZERO 2'h0
`define PIECE_ONE 2'h1

`define LONG_MASK 36'hF_FFFF_FFFF
`define WORD_MASK 36'h0_0003_FFFF
`define BYTE_MASK 36'h0_0000_01FF

`define ALMOST_EMPTY_N_RESET 1'b0
`define ALMOST_FULL_N_RESET 1'b1
`define MAILBOX_FULL_N_RESET 1'b1
`define EDGE_PREV_RESET 1'b1

`endif

// ### pkg/fifo_flag_pkg.sv
// types shared by the almost-flag and mailbox block
`default_nettype none
`include "fifo_flag_defs.svh"
package fifo_flag_pkg;

   typedef logic [`PTR_W-1:0] ptr_type;
   typedef logic [`DATA_W-1:0] word_type;

   typedef struct packed {
      logic select_n;
      logic write_read;
      logic mailbox_sel;
      word_type data;
   } port_cmd_type;

   typedef struct packed {
      ptr_type a2b_wr;
      ptr_type a2b_rd;
      ptr_type b2a_wr;
      ptr_type b2a_rd;
      logic [1:0] b_wr_piece;
      logic [1:0] b_rd_piece;
      logic [`SYNC_CHAINS-1:0][`SYNC_STAGES-1:0][`PTR_W-1:0] sync;
      word_type a2b_mbx;
      word_type b2a_mbx;
      logic a2b_full_n;
      logic b2a_full_n;
      logic a2b_release;
      logic b2a_release;
      logic aea_n;
      logic afa_n;
      logic afb_n;
   } main_state_type;

endpackage
`default_nettype wire

// ### logic/port_edge.sv
// rising-edge pulse from a sampled port clock level
`timescale 1ns/10ps
`default_nettype none
module port_edge
   import fifo_flag_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic level,
   output logic rise
);

   typedef struct packed {
      logic prev;
   } edge_state_type;

   edge_state_type s;
   edge_state_type next_s;

   // prev resets high so a clock that is high at release gives no false edge
   always_comb begin
      next_s = s;
      next_s.prev = level;
      rise = level & ~s.prev;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s.prev <= `EDGE_PREV_RESET;
      end else begin
         s <= next_s;
      end
   end

endmodule
`default_nettype wire

// ### logic/two_entry_buffer.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module two_entry_buffer
   import fifo_flag_pkg::*;
#(
   parameter int WIDTH = `DATA_W
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);

   typedef struct packed {
      logic [WIDTH-1:0] d0;
      logic [WIDTH-1:0] d1;
      logic v0;
      logic v1;
   } buf_state_type;

   buf_state_type s;
   buf_state_type next_s;
   logic pop;
   logic push;

   // ready depends only on state, so no path runs from out_ready to in_ready
   always_comb begin
      next_s = s;
      pop = s.v0 & out_ready;
      push = in_valid & ~s.v1;
      if (pop) begin
         next_s.d0 = s.d1;
         next_s.v0 = s.v1;
         next_s.v1 = 1'b0;
      end
      if (push) begin
         if (!next_s.v0) begin
            next_s.d0 = in_data;
            next_s.v0 = 1'b1;
         end else begin
            next_s.d1 = in_data;
            next_s.v1 = 1'b1;
         end
      end
   end

   assign in_ready = ~s.v1;
   assign out_valid = s.v0;
   assign out_data = s.d0;

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule
`default_nettype wire

// ### logic/bidir_fifo_almost_flags_mailbox.sv
// port-A almost-empty flag, almost-full flags on both ports, and mailbox bus matching
//
// Notes on behaviour
// RL1 - port-A almost-empty rises on first A edge after B write, else one later
// RL2 - word or byte port B counts a queue entry only at its last piece
// RL3 - port-A almost-full rises on next A edge after freeing B read, else later
// RL4 - word or byte port B frees a location only at its last read piece
// RL5 - port-B almost-full rises on next B edge after freeing A read, else later
// RL6 - word or byte port B drops almost-full only on the completing write
// RL7 - almost-full threshold is measured from the full depth, 256 or 1024
// RL8 - A writes and B reads the A-to-B queue with select low, W/R high
// RL9 - B writes the B-to-A queue with select, W/R and mailbox select low
// RL10 - word port B: A-to-B mailbox takes A bits 0-17, B shows bits 0-17
// RL11 - byte port B: A-to-B mailbox takes A bits 0-8, B shows bits 0-8
// RL12 - word port B: B-to-A mailbox takes B bits 0-17, A shows bits 0-17
// RL13 - byte port B: B-to-A mailbox takes B bits 0-8, A shows bits 0-8
// RL14 - mailbox full goes low on writer's edge, released after the other reads
// RL15 - each flag sees the far pointer only after a two-stage synchroniser
`timescale 1ns/10ps
`default_nettype none
module bidir_fifo_almost_flags_mailbox
   import fifo_flag_pkg::*;
#(
   parameter int QUEUE_DEPTH = `DEPTH_SMALL
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic porta_clock,
   input wire logic porta_select_n,
   input wire logic porta_write_read,
   input wire logic porta_mailbox_sel,
   input wire logic [`DATA_W-1:0] porta_data,
   input wire logic portb_clock,
   input wire logic portb_select_n,
   input wire logic portb_write_read,
   input wire logic portb_mailbox_sel,
   input wire logic [`DATA_W-1:0] portb_data,
   input wire logic [1:0] portb_size,
   input wire logic [`PTR_W-1:0] almost_empty_offset,
   input wire logic [`PTR_W-1:0] almost_full_offset,
   output logic porta_almost_empty_n,
   output logic porta_almost_full_n,
   output logic portb_almost_full_n,
   output logic a_to_b_mailbox_full_n,
   output logic b_to_a_mailbox_full_n,
   output logic [`PTR_W-1:0] a_to_b_queue_wr_ptr,
   output logic [`PTR_W-1:0] a_to_b_queue_rd_ptr,
   output logic [`PTR_W-1:0] b_to_a_queue_wr_ptr,
   output logic [`PTR_W-1:0] b_to_a_queue_rd_ptr,
   output logic porta_mailbox_valid,
   output logic [`DATA_W-1:0] porta_mailbox_data,
   input wire logic porta_mailbox_ready,
   output logic portb_mailbox_valid,
   output logic [`DATA_W-1:0] portb_mailbox_data,
   input wire logic portb_mailbox_ready
);

   localparam ptr_type DEPTH_P = ptr_type'(QUEUE_DEPTH);

   main_state_type s;
   main_state_type next_s;

   port_cmd_type cmd_a;
   port_cmd_type cmd_b;
   logic a_rise;
   logic b_rise;
   logic a_buf_ready;
   logic b_buf_ready;
   logic a_push;
   logic b_push;
   word_type a_push_data;
   word_type b_push_data;

   logic a_q_write;
   logic a_q_read;
   logic a_mbx_write;
   logic a_mbx_read;
   logic b_q_write;
   logic b_q_read;
   logic b_mbx_write;
   logic b_mbx_read;
   logic a_sets_b2a_release;
   logic b_sets_a2b_release;
   ptr_type full_threshold;
   ptr_type tap_a2b_rd;
   ptr_type tap_b2a_wr;
   ptr_type tap_b2a_rd;
   ptr_type tap_a2b_wr;
   ptr_type [`SYNC_CHAINS-1:0] sync_src;

   // occupancy in long words; pointers wrap at twice the largest depth
   function automatic ptr_type level_of(input ptr_type wr, input ptr_type rd);
      level_of = wr - rd;
   endfunction

   // the far pointer arrives late, so a side may refuse early but never over- or underrun
   function automatic logic has_room(input ptr_type wr, input ptr_type rd);
      has_room = level_of(wr, rd) < DEPTH_P;
   endfunction

   function automatic logic has_data(input ptr_type wr, input ptr_type rd);
      has_data = level_of(wr, rd) != `PTR_ZERO;
   endfunction

   // one decode for both ports; only the sense of write/read differs between them
   function automatic logic cmd_hit(input port_cmd_type cmd, input logic wr, input logic mb);
      cmd_hit = ~cmd.select_n & (cmd.write_read == wr) & (cmd.mailbox_sel == mb);
   endfunction

   function automatic logic last_piece(input logic [1:0] piece, input logic [1:0] size);
      case (size)
         `SIZE_WORD: last_piece = (piece == `LAST_PIECE_WORD);
         `SIZE_BYTE: last_piece = (piece == `LAST_PIECE_BYTE);
         default: last_piece = (piece == `LAST_PIECE_LONG);
      endcase
   endfunction

   // unused upper lanes are driven as zero rather than left floating
   function automatic word_type mask_by_size(input word_type d, input logic [1:0] size);
      case (size)
         `SIZE_WORD: mask_by_size = d & `WORD_MASK;
         `SIZE_BYTE: mask_by_size = d & `BYTE_MASK;
         default: mask_by_size = d & `LONG_MASK;
      endcase
   endfunction

   port_edge a_edge (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .level(porta_clock),
      .rise(a_rise)
   );

   port_edge b_edge (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .level(portb_clock),
      .rise(b_rise)
   );

   always_comb begin
      cmd_a.select_n = porta_select_n;
      cmd_a.write_read = porta_write_read;
      cmd_a.mailbox_sel = porta_mailbox_sel;
      cmd_a.data = porta_data;
      cmd_b.select_n = portb_select_n;
      cmd_b.write_read = portb_write_read;
      cmd_b.mailbox_sel = portb_mailbox_sel;
      cmd_b.data = portb_data;
   end

   // port A: W/R high writes, low reads; port B: W/R high reads, low writes
   always_comb begin
      a_q_write = a_rise & cmd_hit(cmd_a, 1'b1, 1'b0); // RL8
      a_q_read = a_rise & cmd_hit(cmd_a, 1'b0, 1'b0);
      a_mbx_write = a_rise & cmd_hit(cmd_a, 1'b1, 1'b1);
      a_mbx_read = a_rise & cmd_hit(cmd_a, 1'b0, 1'b1);
      b_q_read = b_rise & cmd_hit(cmd_b, 1'b1, 1'b0); // RL8
      b_q_write = b_rise & cmd_hit(cmd_b, 1'b0, 1'b0); // RL9
      b_mbx_write = b_rise & cmd_hit(cmd_b, 1'b0, 1'b1);
      b_mbx_read = b_rise & cmd_hit(cmd_b, 1'b1, 1'b1);
   end

   // a mailbox read is only taken while the reader's buffer has room
   always_comb begin
      a_sets_b2a_release = a_mbx_read & ~s.b2a_full_n & a_buf_ready;
      b_sets_a2b_release = b_mbx_read & ~s.a2b_full_n & b_buf_ready;
      a_push = a_sets_b2a_release;
      b_push = b_sets_a2b_release;
      a_push_data = s.b2a_mbx;
      b_push_data = s.a2b_mbx;
   end

   always_comb begin
      tap_a2b_rd = s.sync[`CH_A2B_RD][`SYNC_STAGES-1];
      tap_b2a_wr = s.sync[`CH_B2A_WR][`SYNC_STAGES-1];
      tap_b2a_rd = s.sync[`CH_B2A_RD][`SYNC_STAGES-1];
      tap_a2b_wr = s.sync[`CH_A2B_WR][`SYNC_STAGES-1];
      full_threshold = DEPTH_P - almost_full_offset; // RL7
      sync_src[`CH_A2B_RD] = s.a2b_rd;
      sync_src[`CH_B2A_WR] = s.b2a_wr;
      sync_src[`CH_B2A_RD] = s.b2a_rd;
      sync_src[`CH_A2B_WR] = s.a2b_wr;
   end

   always_comb begin
      next_s = s;

      // far pointers reach the flag logic only through the chain's last stage
      for (int c = 0; c < `SYNC_CHAINS; c++) begin
         next_s.sync[c][0] = sync_src[c]; // RL15
         for (int st = 1; st < `SYNC_STAGES; st++) begin
            next_s.sync[c][st] = s.sync[c][st-1]; // RL15
         end
      end

      if (a_rise) begin
         if (a_q_write && has_room(s.a2b_wr, tap_a2b_rd)) begin
            next_s.a2b_wr = s.a2b_wr + `PTR_ONE;
         end
         if (a_q_read && has_data(tap_b2a_wr, s.b2a_rd)) begin
            next_s.b2a_rd = s.b2a_rd + `PTR_ONE;
         end
         // a B edge less than the skew before this edge shows one A edge later
         next_s.afa_n = level_of(next_s.a2b_wr, tap_a2b_rd) < full_threshold; // RL3
         next_s.aea_n = level_of(tap_b2a_wr, next_s.b2a_rd) > almost_empty_offset; // RL1
         if (a_mbx_write) begin
            next_s.a2b_mbx = mask_by_size(cmd_a.data, portb_size); // RL10 RL11
            next_s.a2b_full_n = 1'b0; // RL14
            next_s.a2b_release = 1'b0;
         end else if (s.a2b_release && !b_sets_a2b_release) begin
            next_s.a2b_full_n = 1'b1; // RL14
            next_s.a2b_release = 1'b0;
         end
      end

      if (b_rise) begin
         if (b_q_read && has_data(tap_a2b_wr, s.a2b_rd)) begin
            if (last_piece(s.b_rd_piece, portb_size)) begin
               next_s.a2b_rd = s.a2b_rd + `PTR_ONE; // RL4
               next_s.b_rd_piece = `PIECE_ZERO;
            end else begin
               next_s.b_rd_piece = s.b_rd_piece + `PIECE_ONE;
            end
         end
         if (b_q_write && has_room(s.b2a_wr, tap_b2a_rd)) begin
            if (last_piece(s.b_wr_piece, portb_size)) begin
               next_s.b2a_wr = s.b2a_wr + `PTR_ONE; // RL2
               next_s.b_wr_piece = `PIECE_ZERO;
            end else begin
               next_s.b_wr_piece = s.b_wr_piece + `PIECE_ONE;
            end
         end
         // only a completed long word moves the write pointer, so the flag
         // can fall on the final piece and never earlier
         next_s.afb_n = level_of(next_s.b2a_wr, tap_b2a_rd) < full_threshold; // RL5 RL6
         if (b_mbx_write) begin
            next_s.b2a_mbx = mask_by_size(cmd_b.data, portb_size); // RL12 RL13
            next_s.b2a_full_n = 1'b0; // RL14
            next_s.b2a_release = 1'b0;
         end else if (s.b2a_release && !a_sets_b2a_release) begin
            next_s.b2a_full_n = 1'b1; // RL14
            next_s.b2a_release = 1'b0;
         end
      end

      // a new read request outranks the clear taken on the writer's edge
      if (b_sets_a2b_release) begin
         next_s.a2b_release = 1'b1; // RL14
      end
      if (a_sets_b2a_release) begin
         next_s.b2a_release = 1'b1; // RL14
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.aea_n <= `ALMOST_EMPTY_N_RESET;
         s.afa_n <= `ALMOST_FULL_N_RESET;
         s.afb_n <= `ALMOST_FULL_N_RESET;
         s.a2b_full_n <= `MAILBOX_FULL_N_RESET;
         s.b2a_full_n <= `MAILBOX_FULL_N_RESET;
      end else begin
         s <= next_s;
      end
   end

   // port A drains the B-to-A mailbox, port B the A-to-B mailbox
   two_entry_buffer #(
      .WIDTH(`DATA_W)
   ) a_mbx_buf (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .in_valid(a_push),
      .in_data(a_push_data),
      .in_ready(a_buf_ready),
      .out_valid(porta_mailbox_valid),
      .out_data(porta_mailbox_data),
      .out_ready(porta_mailbox_ready)
   );

   two_entry_buffer #(
      .WIDTH(`DATA_W)
   ) b_mbx_buf (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .in_valid(b_push),
      .in_data(b_push_data),
      .in_ready(b_buf_ready),
      .out_valid(portb_mailbox_valid),
      .out_data(portb_mailbox_data),
      .out_ready(portb_mailbox_ready)
   );

   assign porta_almost_empty_n = s.aea_n;
   assign porta_almost_full_n = s.afa_n;
   assign portb_almost_full_n = s.afb_n;
   assign a_to_b_mailbox_full_n = s.a2b_full_n;
   assign b_to_a_mailbox_full_n = s.b2a_full_n;
   assign a_to_b_queue_wr_ptr = s.a2b_wr;
   assign a_to_b_queue_rd_ptr = s.a2b_rd;
   assign b_to_a_queue_wr_ptr = s.b2a_wr;
   assign b_to_a_queue_rd_ptr = s.b2a_rd;

endmodule
`default_nettype wire

// ### bench/port_host.sv
// host model for one port: one port clock pulse per command
`timescale 1ns/10ps
`default_nettype none
module port_host
   import fifo_flag_pkg::*;
(
   input wire logic ref_clk,
   input wire logic go,
   input wire port_cmd_type cmd,
   output logic pclk,
   output var port_cmd_type bus,
   output logic done
);
   // clock stands still between commands; released lines show the inverse
   initial begin
      pclk = 1'h0;
      done = 1'h0;
      bus = '{1'h1, 1'h0, 1'h0, '0};
      forever begin
         @(posedge ref_clk iff go);
         #1 bus = cmd;
         pclk = 1'h1;
         repeat (2) @(posedge ref_clk);
         #1 pclk = 1'h0;
         repeat (2) @(posedge ref_clk);
         #1 bus = '{1'h1, ~cmd.write_read, ~cmd.mailbox_sel, ~cmd.data};
         done = 1'h1;
         @(posedge ref_clk);
         #1 done = 1'h0;
      end
   end
endmodule
`default_nettype wire

// ### bench/fifo_flag_properties.sv
// port assertions for the almost-flag and mailbox block
`timescale 1ns/10ps
`default_nettype none
module fifo_flag_properties
   import fifo_flag_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic porta_clock,
   input wire logic porta_select_n,
   input wire logic porta_write_read,
   input wire logic porta_mailbox_sel,
   input wire logic portb_clock,
   input wire logic portb_select_n,
   input wire logic portb_write_read,
   input wire logic portb_mailbox_sel,
   input wire logic porta_almost_empty_n,
   input wire logic porta_almost_full_n,
   input wire logic portb_almost_full_n,
   input wire logic a_to_b_mailbox_full_n,
   input wire logic b_to_a_mailbox_full_n
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   sequence a_rise;
      porta_clock && !$past(porta_clock);
   endsequence
   sequence b_rise;
      portb_clock && !$past(portb_clock);
   endsequence
   // a flag moving on the far clock would be a metastability hazard
   chk_ae_own_edge: assert property ($changed(porta_almost_empty_n) |->
      $past(porta_clock) && !$past(porta_clock, 2)) else $error("almost-empty off A rise");
   chk_fa_own_edge: assert property ($changed(porta_almost_full_n) |->
      $past(porta_clock) && !$past(porta_clock, 2)) else $error("A almost-full off A rise");
   chk_fb_own_edge: assert property ($changed(portb_almost_full_n) |->
      $past(portb_clock) && !$past(portb_clock, 2)) else $error("B almost-full off B rise");
   chk_fa_fall_write: assert property ($fell(porta_almost_full_n) |->
      $past(!porta_select_n && porta_write_read && !porta_mailbox_sel)) else $error("A fall");
   chk_fb_fall_write: assert property ($fell(portb_almost_full_n) |->
      $past(!portb_select_n && !portb_write_read && !portb_mailbox_sel)) else $error("B fall");
   chk_a_mbx_full: assert property (a_rise ##0 (!porta_select_n && porta_write_read &&
      porta_mailbox_sel) |=> !a_to_b_mailbox_full_n) else $error("a-to-b mailbox not full");
   chk_b_mbx_full: assert property (b_rise ##0 (!portb_select_n && !portb_write_read &&
      portb_mailbox_sel) |=> !b_to_a_mailbox_full_n) else $error("b-to-a mailbox not full");
   chk_a_mbx_release: assert property ($rose(a_to_b_mailbox_full_n) |->
      $past(porta_clock) && !$past(porta_clock, 2)) else $error("a-to-b release off A rise");
endmodule
bind bidir_fifo_almost_flags_mailbox fifo_flag_properties i_props (.ref_clk(ref_clk),
   .rstn(rstn), .porta_clock(porta_clock), .porta_select_n(porta_select_n),
   .porta_write_read(porta_write_read), .porta_mailbox_sel(porta_mailbox_sel),
   .portb_clock(portb_clock), .portb_select_n(portb_select_n),
   .portb_write_read(portb_write_read), .portb_mailbox_sel(portb_mailbox_sel),
   .porta_almost_empty_n(porta_almost_empty_n), .porta_almost_full_n(porta_almost_full_n),
   .portb_almost_full_n(portb_almost_full_n), .a_to_b_mailbox_full_n(a_to_b_mailbox_full_n),
   .b_to_a_mailbox_full_n(b_to_a_mailbox_full_n));
`default_nettype wire

// ### bench/testbench.sv
// bench: host models on both ports, flag and mailbox checks for each port-B size
`timescale 1ns/10ps
`default_nettype none
module testbench
   import fifo_flag_pkg::*;
;
   logic ref_clk, rstn, ga, gb, dna, dnb, cka, ckb, rya, ryb, emp, fla, flb, mfa, mfb, va, vb;
   logic [1:0] size;
   ptr_type wa, ra, wb, rb;
   port_cmd_type ca, cb, ba, bb;
   word_type da, db, d, mask;
   word_type qa[$], qb[$];
   integer mismatches, compares, seed, n, k, r;
   bidir_fifo_almost_flags_mailbox #(.QUEUE_DEPTH(`DEPTH_LARGE)) i_dut (.ref_clk(ref_clk),
      .rstn(rstn), .porta_clock(cka), .porta_select_n(ba.select_n),
      .porta_write_read(ba.write_read), .porta_mailbox_sel(ba.mailbox_sel),
      .porta_data(ba.data), .portb_clock(ckb), .portb_select_n(bb.select_n),
      .portb_write_read(bb.write_read), .portb_mailbox_sel(bb.mailbox_sel),
      .portb_data(bb.data), .portb_size(size), .almost_empty_offset(`PTR_ZERO),
      .almost_full_offset(ptr_type'(`DEPTH_LARGE - 1)), .porta_almost_empty_n(emp),
      .porta_almost_full_n(fla), .portb_almost_full_n(flb), .a_to_b_mailbox_full_n(mfa),
      .b_to_a_mailbox_full_n(mfb), .a_to_b_queue_wr_ptr(wa), .a_to_b_queue_rd_ptr(ra),
      .b_to_a_queue_wr_ptr(wb), .b_to_a_queue_rd_ptr(rb), .porta_mailbox_valid(va),
      .porta_mailbox_data(da), .porta_mailbox_ready(rya), .portb_mailbox_valid(vb),
      .portb_mailbox_data(db), .portb_mailbox_ready(ryb));
   port_host i_host_a (.ref_clk(ref_clk), .go(ga), .cmd(ca), .pclk(cka), .bus(ba), .done(dna));
   port_host i_host_b (.ref_clk(ref_clk), .go(gb), .cmd(cb), .pclk(ckb), .bus(bb), .done(dnb));
   initial begin
      ref_clk = 1'h0;
      forever #10 ref_clk = ~ref_clk;
   end
   // random consumer stalls exercise the two-entry buffers
   always @(posedge ref_clk) begin
      if (va === 1'h1 && rya === 1'h1) begin
         qa.push_back(da);
      end
      if (vb === 1'h1 && ryb === 1'h1) begin
         qb.push_back(db);
      end
      #1 r = $random(seed);
      rya = r[0];
      ryb = r[1];
   end
   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp_flag(string nm, logic e, logic g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp_val(string nm, word_type e, word_type g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic op(logic b, logic sn, logic wr, logic mb, word_type dt);
      int i;
      if (b) begin
         cb = '{sn, wr, mb, dt};
         gb = 1'h1;
      end else begin
         ca = '{sn, wr, mb, dt};
         ga = 1'h1;
      end
      @(posedge ref_clk);
      #1 ga = 1'h0;
      gb = 1'h0;
      for (i = 0; i < 20 && (b ? dnb : dna) !== 1'h1; i++) begin
         @(posedge ref_clk);
      end
      if (i == 20) begin
         mismatches++;
         $display("MISMATCH port_done expected 1 seen timeout");
      end
      #1;
   endtask
   task automatic pull(logic b, word_type e);
      int i;
      word_type w;
      for (i = 0; i < 50 && (b ? qb.size() : qa.size()) == 0; i++) begin
         @(posedge ref_clk);
      end
      #1;
      if (i == 50) begin
         mismatches++;
         $display("MISMATCH mailbox_pull expected word seen none");
      end else begin
         w = b ? qb.pop_front() : qa.pop_front();
      end
      cmp_val("mailbox_data", e, w);
   endtask
   initial begin
      #200000;
      mismatches++;
      end_sim();
   end
   initial begin
      seed = 32'hBDF3;
      mismatches = 0;
      compares = 0;
      {rstn, ga, gb, ca, cb, size} = '0;
      for (int s = 0; s < 3; s++) begin
         size = 2'(s);
         n = 1 << s;
         mask = s == 0 ? `LONG_MASK : s == 1 ? `WORD_MASK : `BYTE_MASK;
         rstn = 1'h0;
         repeat (8) @(posedge ref_clk);
         #1 rstn = 1'h1;
         cmp_flag("almost_empty_n", 1'h0, emp);
         d = word_type'({$random(seed), $random(seed)});
         op(0, 0, 1, 1, d);
         cmp_flag("a_to_b_full_n", 1'h0, mfa);
         op(1, 0, 1, 1, '0);
         pull(1, d & mask);
         op(0, 1, 0, 0, '0);
         cmp_flag("a_to_b_full_n", 1'h1, mfa);
         d = word_type'({$random(seed), $random(seed)});
         op(1, 0, 0, 1, d);
         cmp_flag("b_to_a_full_n", 1'h0, mfb);
         op(0, 0, 0, 1, '0);
         pull(0, d & mask);
         op(1, 1, 0, 0, '0);
         cmp_flag("b_to_a_full_n", 1'h1, mfb);
         for (k = 0; k < n; k++) begin
            op(1, 0, 0, 0, d);
            cmp_val("b_to_a_wr_ptr", word_type'(k == n - 1), word_type'(wb));
            cmp_flag("b_almost_full_n", k != n - 1, flb);
         end
         op(0, 1, 0, 0, '0);
         cmp_flag("almost_empty_n", 1'h1, emp);
         op(0, 0, 0, 0, '0);
         cmp_val("b_to_a_rd_ptr", 36'h1, word_type'(rb));
         cmp_flag("almost_empty_n", 1'h0, emp);
         op(1, 1, 0, 0, '0);
         cmp_flag("b_almost_full_n", 1'h1, flb);
         op(0, 0, 1, 0, d);
         cmp_val("a_to_b_wr_ptr", 36'h1, word_type'(wa));
         cmp_flag("a_almost_full_n", 1'h0, fla);
         for (k = 0; k < n; k++) begin
            op(1, 0, 1, 0, '0);
            cmp_val("a_to_b_rd_ptr", word_type'(k == n - 1), word_type'(ra));
         end
         op(0, 1, 0, 0, '0);
         cmp_flag("a_almost_full_n", 1'h1, fla);
      end
      end_sim();
   end
endmodule
`default_nettype wire
